// >>> hdl/swg_guard.sv
`default_nettype none

module swg_guard (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  // Frame events from the network side
  input  wire logic             net_sof,
  input  wire logic             net_frame_proto,
  // Network side byte access
  input  wire swg_pkg::swg_req_t net_req,
  output var  swg_pkg::swg_rsp_t net_rsp,
  output logic                  net_wr_allow,
  output logic                  net_wr_blocked,
  // Local host interface byte access
  input  wire swg_pkg::swg_req_t host_req,
  output var  swg_pkg::swg_rsp_t host_rsp,
  // Link control bits held elsewhere
  input  wire logic [31:0]      link_control_reg,
  // Memory loader
  input  wire logic             eep_load_done,
  input  wire logic [15:0]      eep_word4,
  // Fixed-address matching
  input  wire logic [15:0]      cmd_station,
  output logic                  station_match,
  // Frame disposal
  output logic                  frame_drop
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0] node_address_ff;
  logic [15:0] node_alias_ff;
  logic        alias_loaded_ff;
  logic        reg_unlock_ff;
  logic        reg_guard_ff;
  logic        dev_unlock_ff;
  logic        dev_guard_ff;
  logic        net_wr_blocked_ff;
  logic        frame_drop_ff;
  swg_pkg::swg_rsp_t net_rsp_ff;
  swg_pkg::swg_rsp_t host_rsp_ff;

  logic        nxt_reg_unlock;
  logic        nxt_dev_unlock;
  logic        dev_block;
  logic        reg_block;
  logic        net_wr_ok;
  logic        net_wr_bad;
  logic        reg_guard_off;
  logic        dev_guard_off;
  logic        alias_en;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [7:0] rd_byte(
    input logic [15:0] a,
    input logic [15:0] node,
    input logic [15:0] alias_v,
    input logic        reg_un,
    input logic        reg_gd,
    input logic        dev_un,
    input logic        dev_gd
  );
    logic [7:0] r;
    r = swg_pkg::RD_UNMAPPED;
    if (hit(a, swg_pkg::OFS_NODE_LO)) begin
      r = node[7:0];
    end else if (hit(a, swg_pkg::OFS_NODE_HI)) begin
      r = node[15:8];
    end else if (hit(a, swg_pkg::OFS_ALIAS_LO)) begin
      r = alias_v[7:0];
    end else if (hit(a, swg_pkg::OFS_ALIAS_HI)) begin
      r = alias_v[15:8];
    end else if (hit(a, swg_pkg::OFS_REG_UNLOCK)) begin
      r[swg_pkg::BIT_FLAG] = reg_un;
    end else if (hit(a, swg_pkg::OFS_REG_GUARD)) begin
      r[swg_pkg::BIT_FLAG] = reg_gd;
    end else if (hit(a, swg_pkg::OFS_DEV_UNLOCK)) begin
      r[swg_pkg::BIT_FLAG] = dev_un;
    end else if (hit(a, swg_pkg::OFS_DEV_GUARD)) begin
      r[swg_pkg::BIT_FLAG] = dev_gd;
    end
    rd_byte = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Protection check on the current network write
  always_comb begin
    dev_block = dev_guard_ff && !dev_unlock_ff
                && !hit(net_req.addr, swg_pkg::OFS_DEV_UNLOCK);
    reg_block = reg_guard_ff && !reg_unlock_ff
                && (net_req.addr <= swg_pkg::OFS_RANGE_LAST)
                && !hit(net_req.addr, swg_pkg::OFS_REG_UNLOCK)
                && !hit(net_req.addr, swg_pkg::OFS_DEV_UNLOCK);
  end

  assign net_wr_ok    = net_req.wr && !dev_block && !reg_block;
  assign net_wr_bad   = net_req.wr && (dev_block || reg_block);
  assign net_wr_allow = net_wr_ok && clk_en;

  // Guard bits being written to zero
  assign reg_guard_off = net_wr_ok && hit(net_req.addr, swg_pkg::OFS_REG_GUARD)
                         && !net_req.wdata[swg_pkg::BIT_FLAG];
  assign dev_guard_off = net_wr_ok && hit(net_req.addr, swg_pkg::OFS_DEV_GUARD)
                         && !net_req.wdata[swg_pkg::BIT_FLAG];

  ////////////////////////////////////////////////////////////////////////////
  // Unlock flags: a write in the frame-start cycle belongs to the new frame
  always_comb begin
    nxt_reg_unlock = reg_unlock_ff;
    if (net_sof) begin
      nxt_reg_unlock = swg_pkg::RST_FLAG;
    end
    if (reg_guard_off) begin
      nxt_reg_unlock = swg_pkg::RST_FLAG;
    end
    if (net_wr_ok && hit(net_req.addr, swg_pkg::OFS_REG_UNLOCK)) begin
      nxt_reg_unlock = 1'b1;
    end
  end

  always_comb begin
    nxt_dev_unlock = dev_unlock_ff;
    if (net_sof) begin
      nxt_dev_unlock = swg_pkg::RST_FLAG;
    end
    if (dev_guard_off) begin
      nxt_dev_unlock = swg_pkg::RST_FLAG;
    end
    if (net_wr_ok && hit(net_req.addr, swg_pkg::OFS_DEV_UNLOCK)) begin
      nxt_dev_unlock = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_unlock_ff <= swg_pkg::RST_FLAG;
      dev_unlock_ff <= swg_pkg::RST_FLAG;
    end else if (clk_en) begin
      reg_unlock_ff <= nxt_reg_unlock;
      dev_unlock_ff <= nxt_dev_unlock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Guard bits, written from the network side only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_guard_ff <= swg_pkg::RST_FLAG;
      dev_guard_ff <= swg_pkg::RST_FLAG;
    end else if (clk_en && net_wr_ok) begin
      if (hit(net_req.addr, swg_pkg::OFS_REG_GUARD)) begin
        reg_guard_ff <= net_req.wdata[swg_pkg::BIT_FLAG];
      end
      if (hit(net_req.addr, swg_pkg::OFS_DEV_GUARD)) begin
        dev_guard_ff <= net_req.wdata[swg_pkg::BIT_FLAG];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Node address: network writes, host only reads
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      node_address_ff <= swg_pkg::RST_NODE;
    end else if (clk_en && net_wr_ok) begin
      if (hit(net_req.addr, swg_pkg::OFS_NODE_LO)) begin
        node_address_ff[7:0] <= net_req.wdata;
      end
      if (hit(net_req.addr, swg_pkg::OFS_NODE_HI)) begin
        node_address_ff[15:8] <= net_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Node alias: host writes, first memory load seeds it once
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      alias_loaded_ff <= 1'b0;
    end else if (clk_en && eep_load_done) begin
      alias_loaded_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      node_alias_ff <= swg_pkg::RST_ALIAS;
    end else if (clk_en) begin
      if (eep_load_done && !alias_loaded_ff) begin
        node_alias_ff <= eep_word4;
      end else if (host_req.wr) begin
        if (hit(host_req.addr, swg_pkg::OFS_ALIAS_LO)) begin
          node_alias_ff[7:0] <= host_req.wdata;
        end
        if (hit(host_req.addr, swg_pkg::OFS_ALIAS_HI)) begin
          node_alias_ff[15:8] <= host_req.wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fixed-address matching
  assign alias_en = link_control_reg[swg_pkg::BIT_ALIAS_EN];

  always_comb begin
    station_match = (cmd_station == node_address_ff);
    if (alias_en && (cmd_station == node_alias_ff)) begin
      station_match = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answers, one cycle after the request
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      net_rsp_ff <= '0;
    end else if (clk_en) begin
      net_rsp_ff.valid <= net_req.rd;
      if (net_req.rd) begin
        net_rsp_ff.data <= rd_byte(net_req.addr, node_address_ff, node_alias_ff,
                                   reg_unlock_ff, reg_guard_ff, dev_unlock_ff, dev_guard_ff);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      host_rsp_ff <= '0;
    end else if (clk_en) begin
      host_rsp_ff.valid <= host_req.rd;
      if (host_req.rd) begin
        host_rsp_ff.data <= rd_byte(host_req.addr, node_address_ff, node_alias_ff,
                                    reg_unlock_ff, reg_guard_ff, dev_unlock_ff, dev_guard_ff);
      end
    end
  end

  assign net_rsp  = net_rsp_ff;
  assign host_rsp = host_rsp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Blocked-write report, frame processing carries on
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      net_wr_blocked_ff <= 1'b0;
    end else if (clk_en) begin
      net_wr_blocked_ff <= net_wr_bad;
    end
  end

  assign net_wr_blocked = net_wr_blocked_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Frame disposal, decided at frame start and held for the frame
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      frame_drop_ff <= 1'b0;
    end else if (clk_en && net_sof) begin
      frame_drop_ff <= link_control_reg[swg_pkg::BIT_FWD_RULE]
                       && !net_frame_proto;
    end
  end

  assign frame_drop = frame_drop_ff;

endmodule : swg_guard

`default_nettype wire

// >>> hdl/swg_pkg.sv
`default_nettype none

package swg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte offsets
  localparam logic [15:0] OFS_NODE_LO     = 16'h0010;
  localparam logic [15:0] OFS_NODE_HI     = 16'h0011;
  localparam logic [15:0] OFS_ALIAS_LO    = 16'h0012;
  localparam logic [15:0] OFS_ALIAS_HI    = 16'h0013;
  localparam logic [15:0] OFS_REG_UNLOCK  = 16'h0020;
  localparam logic [15:0] OFS_REG_GUARD   = 16'h0021;
  localparam logic [15:0] OFS_DEV_UNLOCK  = 16'h0030;
  localparam logic [15:0] OFS_DEV_GUARD   = 16'h0031;
  localparam logic [15:0] OFS_RANGE_LAST  = 16'h0f7f;

  ////////////////////////////////////////////////////////////////////////////
  // Fields and reset values
  localparam int          BIT_FLAG        = 0;
  localparam int          BIT_ALIAS_EN    = 24;
  localparam int          BIT_FWD_RULE    = 0;
  localparam logic [15:0] RST_NODE        = 16'h0000;
  localparam logic [15:0] RST_ALIAS       = 16'h0000;
  localparam logic        RST_FLAG        = 1'b0;
  localparam logic [7:0]  RD_UNMAPPED     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } swg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } swg_rsp_t;

endpackage : swg_pkg

`default_nettype wire

// >>> tb/swg_guard_monitor.sv
`default_nettype none

module swg_guard_monitor (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic              clk_en,
  // Network side
  input wire logic              net_sof,
  input wire logic              net_frame_proto,
  input wire swg_pkg::swg_req_t net_req,
  input wire swg_pkg::swg_rsp_t net_rsp,
  input wire logic              net_wr_allow,
  input wire logic              net_wr_blocked,
  // Host side and link control
  input wire swg_pkg::swg_req_t host_req,
  input wire swg_pkg::swg_rsp_t host_rsp,
  input wire logic [31:0]       link_control_reg,
  input wire logic              frame_drop
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////
  net_answer_a: assert property (clk_en && net_req.rd |=> net_rsp.valid)
    else $error("net read unanswered");
  net_hold_a: assert property (clk_en && !net_req.rd |=> !net_rsp.valid && $stable(net_rsp.data))
    else $error("net answer not held");
  host_hold_a: assert property (clk_en && !host_req.rd |=> !host_rsp.valid && $stable(host_rsp.data))
    else $error("host answer not held");
  frozen_outputs_a: assert property (!clk_en |=> $stable(net_rsp) && $stable(net_wr_blocked))
    else $error("outputs moved while frozen");
  host_answer_a: assert property (clk_en && host_req.rd |=> host_rsp.valid)
    else $error("host read unanswered");
  allow_cause_a: assert property (net_wr_allow |-> net_req.wr && clk_en)
    else $error("allow without write");
  dev_open_a: assert property (clk_en && net_req.wr && net_req.addr == 16'h0030 |-> net_wr_allow)
    else $error("device unlock write refused");
  blocked_pulse_a: assert property (clk_en && net_req.wr && !net_wr_allow |=> net_wr_blocked)
    else $error("blocked pulse missing");
  no_block_a: assert property (clk_en && !(net_req.wr && !net_wr_allow) |=> !net_wr_blocked)
    else $error("spurious blocked pulse");
  drop_set_a: assert property (clk_en && net_sof |=>
    frame_drop == ($past(link_control_reg[0]) && !$past(net_frame_proto)))
    else $error("frame drop wrong");
  drop_hold_a: assert property (!(clk_en && net_sof) |=> $stable(frame_drop))
    else $error("frame drop moved");
endmodule // swg_guard_monitor

bind swg_guard swg_guard_monitor u_mon (.mclk, .rstn, .clk_en, .net_sof, .net_frame_proto, .net_req, .net_rsp,
  .net_wr_allow, .net_wr_blocked, .host_req, .host_rsp, .link_control_reg, .frame_drop);

`default_nettype wire

// >>> tb/swg_net_master.sv
`default_nettype none

module swg_net_master (
  // Clock
  input  wire logic              mclk,
  // Requests and frame events
  output var  swg_pkg::swg_req_t net_req,
  output var  logic              net_sof,
  output var  logic              net_frame_proto,
  // Answers
  input  wire swg_pkg::swg_rsp_t net_rsp,
  input  wire logic              net_wr_allow
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    net_req = '0;
    net_sof = 1'b0;
    net_frame_proto = 1'b1;
  end

  // Byte access; released lines show the inverse
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, output logic ok, output logic [7:0] q);
    @(posedge mclk);
    net_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    #1 ok = net_wr_allow;
    @(posedge mclk);
    net_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1 q = net_rsp.data;
  endtask

  task automatic sof(input logic proto);
    @(posedge mclk);
    net_sof <= 1'b1;
    net_frame_proto <= proto;
    @(posedge mclk);
    net_sof <= 1'b0;
  endtask

  // New frame, unlock byte first
  task automatic unlock(input logic [15:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    sof(1'b1);
    acc(1'b1, a, d, ok, q);
  endtask
endmodule // swg_net_master

`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic              mclk, rstn, clk_en, eep_load_done, station_match, frame_drop;
  logic              net_sof, net_frame_proto, net_wr_allow, net_wr_blocked, ok, rg, ru, dg, du;
  logic [31:0]       lcr;
  logic [15:0]       eep_word4, cmd_station, node, als, a;
  logic [7:0]        q, d;
  int                err_count, n_compared;
  swg_pkg::swg_req_t net_req, host_req;
  swg_pkg::swg_rsp_t net_rsp, host_rsp;
  logic [15:0]       pick [8] = '{16'h0010, 16'h0011, 16'h0020, 16'h0021, 16'h0030, 16'h0031, 16'h0f7f, 16'h0f80};

  swg_guard dut (.mclk, .rstn, .clk_en, .net_sof, .net_frame_proto, .net_req, .net_rsp, .net_wr_allow,
    .net_wr_blocked, .host_req, .host_rsp, .link_control_reg(lcr), .eep_load_done, .eep_word4,
    .cmd_station, .station_match, .frame_drop);
  swg_net_master m (.mclk, .net_req, .net_sof, .net_frame_proto, .net_rsp, .net_wr_allow);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic exp_ok(input logic [15:0] x);
    return !((dg && !du && x != 16'h0030) || (rg && !ru && x <= 16'h0f7f && x != 16'h0020 && x != 16'h0030));
  endfunction

  function automatic logic [7:0] rdval(input logic [15:0] x);
    case (x)
      16'h0010: return node[7:0];
      16'h0011: return node[15:8];
      16'h0012: return als[7:0];
      16'h0013: return als[15:8];
      16'h0020: return {7'h00, ru};
      16'h0021: return {7'h00, rg};
      16'h0030: return {7'h00, du};
      16'h0031: return {7'h00, dg};
      default:  return 8'h00;
    endcase
  endfunction

  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic nchk(input logic [15:0] x);
    m.acc(1'b0, x, 8'h00, ok, q);
    cmp("net read", 16'(rdval(x)), 16'(q));
  endtask

  task automatic hacc(input logic w, input logic [15:0] x, input logic [7:0] v);
    @(posedge mclk);
    host_req <= '{wr: w, rd: !w, addr: x, wdata: v};
    @(posedge mclk);
    host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~x, wdata: ~v};
    #1 q = host_rsp.data;
  endtask

  task automatic eep(input logic [15:0] w);
    @(posedge mclk);
    eep_word4 <= w;
    eep_load_done <= 1'b1;
    @(posedge mclk);
    eep_word4 <= ~w;
    eep_load_done <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("Compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    give_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, eep_load_done, rg, ru, dg, du} = '0;
    {eep_word4, cmd_station, node, als} = '0;
    {err_count, n_compared} = '0;
    clk_en = 1'b1;
    lcr = 32'h0000_0001;
    host_req = '0;
    void'($urandom(59828));
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    foreach (pick[i]) nchk(pick[i]);
    nchk(16'h0012);
    nchk(16'h0040);
    als = 16'($urandom);
    eep(als);
    eep(~als);
    nchk(16'h0012);
    nchk(16'h0013);
    d = 8'($urandom);
    hacc(1'b1, 16'h0012, d);
    als[7:0] = d;
    m.acc(1'b1, 16'h0013, ~d, ok, q);
    hacc(1'b1, 16'h0010, d);
    nchk(16'h0012);
    nchk(16'h0013);
    nchk(16'h0010);
    repeat (300) begin
      a = ($urandom_range(3) == 0) ? 16'($urandom) : pick[$urandom_range(7)];
      d = 8'($urandom);
      if ($urandom_range(3) == 0) begin
        a = $urandom_range(1) ? 16'h0030 : 16'h0020;
        {ru, du} = 2'b00;
        m.unlock(a, d, ok);
      end else
        m.acc(1'b1, a, d, ok, q);
      cmp("allow", 16'(exp_ok(a)), 16'(ok));
      if (ok) begin
        case (a)
          16'h0010: node[7:0] = d;
          16'h0011: node[15:8] = d;
          16'h0020: ru = 1'b1;
          16'h0030: du = 1'b1;
          16'h0021: {rg, ru} = {d[0], ru & d[0]};
          16'h0031: {dg, du} = {d[0], du & d[0]};
          default: ;
        endcase
      end
      nchk(pick[$urandom_range(5)]);
      @(posedge mclk);
      cmd_station <= $urandom_range(1) ? node : ($urandom_range(1) ? als : 16'($urandom));
      lcr[24] <= 1'($urandom);
      #1 cmp("match", 16'((cmd_station == node) || (lcr[24] && cmd_station == als)), 16'(station_match));
    end
    @(posedge mclk);
    clk_en <= 1'b0;
    m.acc(1'b1, 16'h0010, ~node[7:0], ok, q);
    cmp("frozen allow", 16'h0000, 16'(ok));
    @(posedge mclk);
    clk_en <= 1'b1;
    nchk(16'h0010);
    hacc(1'b0, 16'h0010, 8'h00);
    cmp("host read", 16'(node[7:0]), 16'(q));
    // Mid-run reset, alias may load once more
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    {node, als, rg, ru, dg, du} = '0;
    foreach (pick[i]) nchk(pick[i]);
    nchk(16'h0013);
    als = 16'($urandom);
    eep(als);
    nchk(16'h0012);
    nchk(16'h0013);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      lcr[0] <= 1'(i >> 1);
      m.sof(1'(i));
      #1 cmp("drop", 16'(lcr[0] && !1'(i)), 16'(frame_drop));
    end
    give_verdict;
  end
endmodule // testbench

`default_nettype wire
